// [sdst_consts.vh]
`ifndef SDST_CONSTS_VH
`define SDST_CONSTS_VH

// Register byte offsets
`define SDST_OFF_CTRL 8'h00
`define SDST_OFF_CONFIG 8'h04
`define SDST_OFF_STATUS 8'h08
`define SDST_OFF_ERROR 8'h0c
`define SDST_OFF_AUX 8'h10

// Control register command bits
`define SDST_CTRL_LOGIC_START 0
`define SDST_CTRL_HALL_START 1

// Configuration word layout and reset value
`define SDST_CFG_PU_LOGIC 19
`define SDST_CFG_PU_HALL 18
`define SDST_CFG_CMD_LOCK 13
`define SDST_CFG_THR_HI 5
`define SDST_CFG_THR_LO 0
`define SDST_CFG_RESET 32'h000c0006
`define SDST_CFG_WMASK 32'h000c203f

// Status and error bits
`define SDST_STA_DONE 0
`define SDST_STA_LOGIC_RUN 1
`define SDST_STA_HALL_RUN 2
`define SDST_STA_LOW_FIELD 3
`define SDST_ERR_SELFTEST 0
`define SDST_ERR_WDOG 1

// Timing
`define SDST_CLK_MHZ 250
`define SDST_ALIVE_PERIOD_US 8192
`define SDST_LOGIC_TEST_US 30000
`define SDST_HALL_TEST_US 52000
`define SDST_FIELD_STEP_G 16
`define SDST_HALL_STEPS 32
`define SDST_WD_MIN 16'h0384
`define SDST_WD_MAX 16'h044c
`define SDST_WD_TICK 16'h03e8
`define SDST_ANGLE_TOL 12'h040

// Logic test seeds and expected signature
`define SDST_LFSR_SEED 31'h00000001
`define SDST_MISR_SEED 31'h00000000
`define SDST_MISR_EXPECT 31'h00000000

// AXI responses
`define SDST_RESP_OKAY 2'b00
`define SDST_RESP_SLVERR 2'b10

`endif

// [sdst_top.v]
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "sdst_consts.vh"

module sdst_top #(
    parameter AW = 8,
    parameter ALIVE_CYCLES = `SDST_ALIVE_PERIOD_US * `SDST_CLK_MHZ,
    parameter LOGIC_CYCLES = `SDST_LOGIC_TEST_US * `SDST_CLK_MHZ,
    parameter HALL_CYCLES = `SDST_HALL_TEST_US * `SDST_CLK_MHZ,
    parameter [30:0] MISR_EXPECT = `SDST_MISR_EXPECT,
    parameter WD_MIN = `SDST_WD_MIN,
    parameter WD_MAX = `SDST_WD_MAX,
    parameter WD_TICK = `SDST_WD_TICK,
    parameter [11:0] ANGLE_TOL = `SDST_ANGLE_TOL,
    parameter FIELD_W = 12
) (
    input wire aclk,
    input wire aresetn,
    input wire [AW-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [AW-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [30:0] scan_chain_in,
    input wire [30:0] scan_chain_out,
    output reg scan_enable,
    output reg hall_test_mode,
    output reg hall_current_dir,
    output reg [3:0] hall_element_sel,
    input wire [11:0] hall_angle,
    input wire hall_angle_valid,
    input wire [FIELD_W-1:0] field_strength,
    output reg low_field_flag,
    input wire osc_ref_tick,
    input wire osc_ref_fault,
    output reg osc_main_tick
);

    localparam STEP_CYCLES = HALL_CYCLES / `SDST_HALL_STEPS;

    reg [31:0] alive_div;
    reg [31:0] alive_count;
    reg [31:0] cfg_word;
    reg err_selftest;
    reg err_wdog;
    reg special_done;
    reg por_pend;
    reg logic_run;
    reg [31:0] logic_cnt;
    reg [30:0] lfsr;
    reg [30:0] misr;
    reg hall_run;
    reg [4:0] hall_step;
    reg [31:0] hall_cnt;
    reg [11:0] hall_seen_angle;
    reg hall_seen;
    reg hall_bad;
    reg [15:0] wd_cnt;
    reg [15:0] wd_tick_cnt;
    reg [31:0] rd_data;
    reg rd_ok;

    wire wr_fire = s_axi_awready;
    wire [AW-1:0] wr_addr = s_axi_awaddr;
    wire sel_ctrl = (wr_addr == `SDST_OFF_CTRL);
    wire sel_cfg = (wr_addr == `SDST_OFF_CONFIG);
    wire sel_err = (wr_addr == `SDST_OFF_ERROR);
    wire [31:0] wstrb_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    // Command lock blocks only the serial starts, never the power-up ones
    wire cmd_ok = wr_fire && sel_ctrl && s_axi_wstrb[0] && !cfg_word[`SDST_CFG_CMD_LOCK];
    wire start_logic = (por_pend && cfg_word[`SDST_CFG_PU_LOGIC]) ||
                       (cmd_ok && s_axi_wdata[`SDST_CTRL_LOGIC_START]);
    wire start_hall = (por_pend && cfg_word[`SDST_CFG_PU_HALL]) ||
                      (cmd_ok && s_axi_wdata[`SDST_CTRL_HALL_START]);
    wire logic_end = logic_run && (logic_cnt == LOGIC_CYCLES - 1);
    wire step_end = hall_run && (hall_cnt == STEP_CYCLES - 1);
    wire hall_end = step_end && (hall_step == 5'd31);
    wire [11:0] expect_angle = {hall_step, 7'h00};
    wire [11:0] angle_err = hall_seen_angle - expect_angle;
    wire angle_ok = hall_seen && ((angle_err < ANGLE_TOL) || (angle_err > (12'hfff - ANGLE_TOL)));
    wire logic_fail = logic_end && (misr != MISR_EXPECT);
    wire hall_fail = hall_end && (hall_bad || !angle_ok);
    wire next_logic_run = start_logic | (logic_run & ~logic_end);
    wire next_hall_run = start_hall | (hall_run & ~hall_end);
    wire err_clr = wr_fire && sel_err && s_axi_wstrb[0];
    wire [36:0] thr_g = {31'h0, cfg_word[`SDST_CFG_THR_HI:`SDST_CFG_THR_LO]} * `SDST_FIELD_STEP_G;
    wire [36:0] field_ext = {{(37-FIELD_W){1'b0}}, field_strength};
    wire [30:0] misr_shift = {misr[29:0], misr[30] ^ misr[27]};
    wire [4:0] next_hall_step = hall_step + 5'h01;
    // A lost reference tick saturates the counter, so it faults on every cycle until the next tick
    wire wd_short = osc_ref_tick && (wd_cnt < WD_MIN);
    wire wd_long = osc_ref_tick && (wd_cnt > WD_MAX);
    wire wd_stuck = !osc_ref_tick && (wd_cnt == WD_MAX + 16'h0001);
    wire wd_fault_now = osc_ref_fault || wd_short || wd_long || wd_stuck;

    // Alive counter and its divider
    always @(posedge aclk) begin
        if (!aresetn) begin
            alive_div <= 32'h00000000;
            alive_count <= 32'h00000000;
        end else if (alive_div == ALIVE_CYCLES - 1) begin
            alive_div <= 32'h00000000;
            alive_count <= alive_count + 32'h00000001;
        end else begin
            alive_div <= alive_div + 32'h00000001;
        end
    end

    // Power-up test request uses the config reset values, one cycle after release
    always @(posedge aclk) begin
        if (!aresetn) begin
            por_pend <= 1'b1;
        end else begin
            por_pend <= 1'b0;
        end
    end

    // Logic self-test: LFSR drives all chains, MISR compacts the returns
    always @(posedge aclk) begin
        if (!aresetn) begin
            logic_run <= 1'b0;
            logic_cnt <= 32'h00000000;
            lfsr <= `SDST_LFSR_SEED;
            misr <= `SDST_MISR_SEED;
            scan_chain_in <= 31'h00000000;
            scan_enable <= 1'b0;
        end else begin
            logic_run <= next_logic_run;
            scan_enable <= next_logic_run;
            if (start_logic) begin
                logic_cnt <= 32'h00000000;
                lfsr <= `SDST_LFSR_SEED;
                misr <= `SDST_MISR_SEED;
                scan_chain_in <= `SDST_LFSR_SEED;
            end else if (logic_run) begin
                logic_cnt <= logic_cnt + 32'h00000001;
                lfsr <= {lfsr[29:0], lfsr[30] ^ lfsr[27]};
                scan_chain_in <= {lfsr[29:0], lfsr[30] ^ lfsr[27]};
                misr <= misr_shift ^ scan_chain_out;
            end
        end
    end

    // Hall-array self-test: 16 elements times two current directions
    always @(posedge aclk) begin
        if (!aresetn) begin
            hall_run <= 1'b0;
            hall_step <= 5'd0;
            hall_cnt <= 32'h00000000;
            hall_seen_angle <= 12'h000;
            hall_seen <= 1'b0;
            hall_bad <= 1'b0;
            hall_test_mode <= 1'b0;
            hall_current_dir <= 1'b0;
            hall_element_sel <= 4'h0;
        end else begin
            hall_run <= next_hall_run;
            hall_test_mode <= next_hall_run;
            if (start_hall) begin
                hall_step <= 5'd0;
                hall_cnt <= 32'h00000000;
                hall_seen <= 1'b0;
                hall_bad <= 1'b0;
                hall_current_dir <= 1'b0;
                hall_element_sel <= 4'h0;
            end else if (step_end) begin
                hall_cnt <= 32'h00000000;
                hall_step <= next_hall_step;
                hall_current_dir <= next_hall_step[4];
                hall_element_sel <= next_hall_step[3:0];
                hall_seen <= 1'b0;
                if (!angle_ok) begin
                    hall_bad <= 1'b1;
                end
            end else if (hall_run) begin
                hall_cnt <= hall_cnt + 32'h00000001;
                if (hall_angle_valid) begin
                    hall_seen_angle <= hall_angle;
                    hall_seen <= 1'b1;
                end
            end
        end
    end

    // Done flag and sticky error flags; a set beats a clear in the same cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            special_done <= 1'b0;
            err_selftest <= 1'b0;
            err_wdog <= 1'b0;
        end else begin
            if (start_logic || start_hall) begin
                special_done <= 1'b0;
            end else if ((logic_run || hall_run) && !next_logic_run && !next_hall_run) begin
                special_done <= 1'b1;
            end
            if (logic_fail || hall_fail) begin
                err_selftest <= 1'b1;
            end else if (err_clr && s_axi_wdata[`SDST_ERR_SELFTEST]) begin
                err_selftest <= 1'b0;
            end
            if (wd_fault_now) begin
                err_wdog <= 1'b1;
            end else if (err_clr && s_axi_wdata[`SDST_ERR_WDOG]) begin
                err_wdog <= 1'b0;
            end
        end
    end

    // Watchdog on the reference oscillator tick; the tick we send lets the other side check us
    always @(posedge aclk) begin
        if (!aresetn) begin
            wd_cnt <= 16'h0000;
            wd_tick_cnt <= 16'h0000;
            osc_main_tick <= 1'b0;
        end else begin
            if (osc_ref_tick) begin
                wd_cnt <= 16'h0000;
            end else if (wd_cnt != WD_MAX + 16'd1) begin
                wd_cnt <= wd_cnt + 16'h0001;
            end
            if (wd_tick_cnt == WD_TICK - 16'd1) begin
                wd_tick_cnt <= 16'h0000;
                osc_main_tick <= 1'b1;
            end else begin
                wd_tick_cnt <= wd_tick_cnt + 16'h0001;
                osc_main_tick <= 1'b0;
            end
        end
    end

    // Low-field comparator
    always @(posedge aclk) begin
        if (!aresetn) begin
            low_field_flag <= 1'b0;
        end else begin
            low_field_flag <= (thr_g != 37'h0) && (field_ext < thr_g);
        end
    end

    // AXI4-Lite write channel; address and data taken together
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SDST_RESP_OKAY;
            cfg_word <= `SDST_CFG_RESET;
        end else begin
            if (s_axi_awready) begin
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (sel_ctrl || sel_cfg || sel_err) begin
                    s_axi_bresp <= `SDST_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `SDST_RESP_SLVERR;
                end
                if (sel_cfg) begin
                    cfg_word <= (cfg_word & ~(`SDST_CFG_WMASK & wstrb_mask)) |
                              (s_axi_wdata & `SDST_CFG_WMASK & wstrb_mask);
                end
            end else begin
                if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid) begin
                    s_axi_awready <= 1'b1;
                    s_axi_wready <= 1'b1;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // Read decode
    always @* begin
        rd_data = 32'h00000000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `SDST_OFF_CTRL: rd_data = 32'h00000000;
            `SDST_OFF_CONFIG: rd_data = cfg_word;
            `SDST_OFF_STATUS: begin
                rd_data[`SDST_STA_DONE] = special_done;
                rd_data[`SDST_STA_LOGIC_RUN] = logic_run;
                rd_data[`SDST_STA_HALL_RUN] = hall_run;
                rd_data[`SDST_STA_LOW_FIELD] = low_field_flag;
            end
            `SDST_OFF_ERROR: begin
                rd_data[`SDST_ERR_SELFTEST] = err_selftest;
                rd_data[`SDST_ERR_WDOG] = err_wdog;
            end
            `SDST_OFF_AUX: rd_data = alive_count;
            default: rd_ok = 1'b0;
        endcase
    end

    // AXI4-Lite read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SDST_RESP_OKAY;
        end else begin
            if (s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_ok ? `SDST_RESP_OKAY : `SDST_RESP_SLVERR;
            end else begin
                if (s_axi_arvalid && !s_axi_rvalid) begin
                    s_axi_arready <= 1'b1;
                end
                if (s_axi_rvalid && s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end
        end
    end

endmodule

// [sdst_properties.sv]
`timescale 1ns/1ps
module sdst_properties #(
    parameter LOGIC_CYCLES = 40
) (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire [30:0] scan_chain_in,
    input wire scan_enable,
    input wire hall_test_mode,
    input wire hall_current_dir,
    input wire [3:0] hall_element_sel,
    input wire osc_main_tick
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Length of the current scan run
    int run_len;
    always @(posedge aclk) begin
        run_len <= (!aresetn || !scan_enable) ? 0 : run_len + 1;
    end
    sequence wr_take;
        s_axi_awready && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arready;
    endsequence
    wr_answer_a: assert property (wr_take |=> s_axi_bvalid) else $error("write answer late");
    rd_answer_a: assert property (rd_take |=> s_axi_rvalid) else $error("read answer late");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    logic_len_a: assert property ($fell(scan_enable) |-> run_len == LOGIC_CYCLES)
        else $error("scan run length wrong");
    logic_max_a: assert property (run_len <= LOGIC_CYCLES) else $error("scan run too long");
    lfsr_moves_a: assert property (scan_enable && $past(scan_enable) |-> scan_chain_in != $past(scan_chain_in))
        else $error("scan stimulus stuck");
    hall_step_a: assert property (hall_test_mode && $past(hall_test_mode) &&
        ($changed(hall_current_dir) || $changed(hall_element_sel)) |->
        {hall_current_dir, hall_element_sel} == {$past(hall_current_dir), $past(hall_element_sel)} + 5'd1)
        else $error("hall step order wrong");
    tick_pulse_a: assert property (osc_main_tick |=> (!osc_main_tick) [*8]) else $error("tick not a pulse");
endmodule
bind sdst_top sdst_properties #(.LOGIC_CYCLES(LOGIC_CYCLES)) u_props (.*);

// [tb.sv]
`timescale 1ns/1ps
`include "sdst_consts.vh"
module tb;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, hall_angle_valid = 0, osc_ref_tick = 0, osc_ref_fault = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic scan_enable, hall_test_mode, hall_current_dir, low_field_flag, osc_main_tick;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, a1;
    logic [3:0] s_axi_wstrb = 4'hf, hall_element_sel;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [30:0] scan_chain_in, scan_chain_out = 0;
    logic [11:0] hall_angle = 0, field_strength = 0;
    logic [5:0] t;
    logic bad_scan = 0, bad_hall = 0;
    int gap = 1000, tcnt = 0, mismatches = 0, comparisons = 0, lag_max = 0;
    // Short counts keep the run brief
    sdst_top #(.ALIVE_CYCLES(8), .LOGIC_CYCLES(40), .HALL_CYCLES(320)) DUT (.*);
    initial forever #2 aclk = ~aclk;
    // Far side: reference ticks, measured angle and scan returns
    always @(posedge aclk) begin
        tcnt <= (tcnt >= gap - 1) ? 0 : tcnt + 1;
        osc_ref_tick <= (tcnt == gap - 1);
        hall_angle_valid <= hall_test_mode;
        hall_angle <= {hall_current_dir, hall_element_sel, 7'h00} + (bad_hall ? 12'h100 : 12'h000);
        scan_chain_out <= bad_scan ? 31'($urandom) : 31'h0;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Ready may lag the answer by a few cycles so the hold checks see a stalled response
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int w, n;
        logic ok;
        w = $urandom % (lag_max + 1);
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= (w == 0);
        do begin
            @(posedge aclk);
            ok = s_axi_bvalid && s_axi_bready;
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            n++;
            if (!ok && n >= w) s_axi_bready <= 1;
        end while (!ok);
        rs = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int w, n;
        logic ok;
        w = $urandom % (lag_max + 1);
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= (w == 0);
        do begin
            @(posedge aclk);
            ok = s_axi_rvalid && s_axi_rready;
            if (s_axi_arready) s_axi_arvalid <= 0;
            n++;
            if (!ok && n >= w) s_axi_rready <= 1;
        end while (!ok);
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0] s;
        rd(a, v, s);
        chk(v & m, e);
    endtask
    // Polls status until the done flag shows, then checks both run flags low
    task automatic wdone;
        logic [31:0] v;
        logic [1:0] s;
        int n;
        n = 0;
        do begin
            rd(`SDST_OFF_STATUS, v, s);
            n++;
        end while (v[0] !== 1'b1 && n < 400);
        chk(v & 32'h7, 32'h1);
    endtask
    function automatic logic lf_exp(input logic [5:0] th, input logic [11:0] f);
        return (th != 0) && (f < {th, 4'h0});
    endfunction
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge aclk);
        mismatches++;
        wrap_up;
    end
    initial begin
        void'($urandom(32'h44b3422c));
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        rd(`SDST_OFF_AUX, a1, r);
        chk(a1, 0);
        rc(`SDST_OFF_STATUS, 32'h7, 32'h6);
        rc(`SDST_OFF_CONFIG, 32'hffffffff, `SDST_CFG_RESET);
        repeat (77) @(posedge aclk);
        rd(`SDST_OFF_AUX, d, r);
        chk(32'(d - a1 >= 9 && d - a1 <= 11), 1);
        lag_max = 3;
        wdone;
        rc(`SDST_OFF_ERROR, 32'h1, 32'h0);
        bad_scan <= 1;
        wr(`SDST_OFF_CTRL, 32'h1, r);
        rc(`SDST_OFF_STATUS, 32'h7, 32'h2);
        wdone;
        rc(`SDST_OFF_ERROR, 32'h1, 32'h1);
        wr(`SDST_OFF_ERROR, 32'h1, r);
        rc(`SDST_OFF_ERROR, 32'h1, 32'h0);
        bad_scan <= 0;
        wr(`SDST_OFF_CTRL, 32'h1, r);
        wdone;
        rc(`SDST_OFF_ERROR, 32'h1, 32'h0);
        bad_hall <= 1;
        wr(`SDST_OFF_CTRL, 32'h2, r);
        rc(`SDST_OFF_STATUS, 32'h7, 32'h4);
        chk(hall_test_mode, 1);
        wdone;
        rc(`SDST_OFF_ERROR, 32'h1, 32'h1);
        wr(`SDST_OFF_ERROR, 32'h1, r);
        bad_hall <= 0;
        wr(`SDST_OFF_CTRL, 32'h3, r);
        rc(`SDST_OFF_STATUS, 32'h7, 32'h6);
        wdone;
        rc(`SDST_OFF_ERROR, 32'h1, 32'h0);
        wr(`SDST_OFF_CONFIG, 32'h000c2000, r);
        wr(`SDST_OFF_CTRL, 32'h3, r);
        rc(`SDST_OFF_STATUS, 32'h7, 32'h1);
        rd(8'h14, d, r);
        chk(d, 32'h0);
        chk(32'(r), 32'(`SDST_RESP_SLVERR));
        wr(`SDST_OFF_AUX, 32'h1, r);
        chk(r, `SDST_RESP_SLVERR);
        for (int i = 0; i < 6; i++) begin
            t = (i == 0) ? 6'h00 : (i == 1) ? 6'h01 : (i == 2) ? 6'h3f : 6'($urandom);
            wr(`SDST_OFF_CONFIG, 32'h000c0000 | t, r);
            for (int k = 0; k < 3; k++) begin
                field_strength <= (k == 0) ? {t, 4'h0} - 1 : (k == 1) ? {t, 4'h0} : 12'($urandom);
                repeat (4) @(posedge aclk);
                chk(low_field_flag, lf_exp(t, field_strength));
            end
        end
        wr(`SDST_OFF_ERROR, 32'h3, r);
        repeat (1500) @(posedge aclk);
        rc(`SDST_OFF_ERROR, 32'h2, 32'h0);
        gap <= 300;
        repeat (1000) @(posedge aclk);
        rc(`SDST_OFF_ERROR, 32'h2, 32'h2);
        wrap_up;
    end
endmodule
